// *** sim/tb_uart_mode_config.sv ***
// self-checking bench for the serial mode configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_uart_mode_config;
    localparam int BITC = 8;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, rxd, cts_n, txd, rts_n;
    logic rx_rts_active, cts_on, rx_level, stop_bit;
    logic [3:0] avs_address, nbits;
    logic [7:0] avs_writedata, avs_readdata, q, frames;
    logic [1:0] channel_mode_field;
    logic [8:0] frame;
    int errors = 0;
    int checks_done = 0;

    umc_top #(.BIT_CYCLES(BITC)) dut (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd),
        .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .channel_mode_field(channel_mode_field),
        .rx_rts_active(rx_rts_active));
    umc_remote #(.BIT_CYCLES(BITC)) remote (.clk(clk), .txd(txd), .cts_on(cts_on),
        .rx_level(rx_level), .nbits(nbits), .cts_n(cts_n), .rxd(rxd), .frame(frame),
        .stop_bit(stop_bit), .frames(frames));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========================================
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle, held until wait request is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        // only the watchdog ends a wait that never answers
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk({1'b0, q}, {1'b0, e});
    endtask : rd
    task automatic ptr_is(input logic e);
        bus(1'b0, umc_pkg::ADDR_STATUS, 8'h00);
        chk({8'h00, q[umc_pkg::ST_PTR_BIT]}, {8'h00, e});
    endtask : ptr_is
    task automatic cmd(input logic [2:0] c);
        bus(1'b1, umc_pkg::ADDR_CMD, {5'h00, c});
    endtask : cmd
    task automatic set_modes(input logic [7:0] m1, input logic [7:0] m2);
        cmd(umc_pkg::CMD_PTR_RESET);
        bus(1'b1, umc_pkg::ADDR_MODE, m1);
        bus(1'b1, umc_pkg::ADDR_MODE, m2);
        // registered copies of the modes settle one edge later
        @(posedge clk);
    endtask : set_modes
    // send one character; hold keeps cts negated for a while first
    task automatic send(input logic [7:0] m1, input logic [7:0] d, input logic hold);
        logic [3:0] n;
        logic [7:0] md, f;
        logic p, pon;
        int k;
        n = 4'h5 + {2'h0, m1[1:0]};
        md = d & (8'hFF >> (4'h8 - n));
        p = (m1[4:3] == umc_pkg::PAR_WITH) ? (^md ^ m1[2]) : m1[2];
        pon = m1[4:3] != umc_pkg::PAR_NONE;
        nbits <= n + {3'h0, pon};
        cmd(umc_pkg::CMD_TX_ENABLE);
        f = frames;
        bus(1'b1, umc_pkg::ADDR_TXDATA, d);
        if (hold) begin
            repeat (4 * BITC) @(posedge clk);
            chk({8'h00, txd}, 9'h001);
            chk({1'b0, frames}, {1'b0, f});
            cts_on <= 1'b1;
        end
        k = 0;
        while (frames === f && k < 40 * BITC) begin
            @(posedge clk);
            k++;
        end
        chk(frame, {1'b0, md} | ({8'h00, p & pon} << n));
        chk({8'h00, stop_bit}, 9'h001);
    endtask : send
    // ==========================================
    task automatic t_pointer;
        rd(umc_pkg::ADDR_MODE, umc_pkg::MODE1_RST);
        ptr_is(1'b1);
        rd(umc_pkg::ADDR_MODE, umc_pkg::MODE2_RST);
        ptr_is(1'b1);
        bus(1'b1, umc_pkg::ADDR_MODE, 8'h30);
        rd(umc_pkg::ADDR_MODE, 8'h30);
        cmd(umc_pkg::CMD_PTR_RESET);
        ptr_is(1'b0);
        bus(1'b1, umc_pkg::ADDR_MODE, 8'h1B);
        rd(umc_pkg::ADDR_MODE, 8'h30);
        cmd(umc_pkg::CMD_PTR_RESET);
        rd(umc_pkg::ADDR_MODE, 8'h1B);
        rd(4'h2, 8'h00);
    endtask : t_pointer
    task automatic t_frames;
        logic [7:0] m1s [7] = '{8'h03, 8'h04, 8'h09, 8'h0E, 8'h17, 8'h1A, 8'h1D};
        for (int i = 0; i < 7; i++) begin
            set_modes(m1s[i], 8'h00);
            send(m1s[i], 8'(8'hB5 + 8'h2F * i), 1'b0);
        end
        set_modes(8'h03, 8'h10);
        send(8'h03, 8'hC9, 1'b1);
        cts_on <= 1'b0;
    endtask : t_frames
    task automatic t_rts(input logic [7:0] m1, input logic [7:0] m2, input logic rel);
        int n;
        set_modes(m1, m2);
        chk({8'h00, rx_rts_active}, {8'h00, m1[7] & !m2[5]});
        cmd(umc_pkg::CMD_RTS_SET);
        send(m1, 8'h5A, 1'b0);
        chk({8'h00, rts_n}, 9'h000);
        repeat (BITC) @(posedge clk);
        cmd(umc_pkg::CMD_TX_DISABLE);
        n = 0;
        while (rts_n !== 1'b1 && n < 4 * BITC) begin
            @(posedge clk);
            n++;
        end
        chk({8'h00, n >= BITC - 1 && n <= BITC + 3}, {8'h00, rel});
        cmd(umc_pkg::CMD_RTS_CLEAR);
    endtask : t_rts
    task automatic t_chmode;
        for (int i = 0; i < 4; i++) begin
            set_modes(8'h03, {i[1:0], 6'h00});
            chk({7'h00, channel_mode_field}, {7'h00, i[1:0]});
            rx_level <= 1'b0;
            repeat (12) @(posedge clk);
            chk({8'h00, txd}, {8'h00, !i[0]});
            rx_level <= 1'b1;
            repeat (12) @(posedge clk);
        end
        set_modes(8'h03, 8'h00);
    endtask : t_chmode
    // ==========================================
    initial begin
        reset = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 8'h00;
        cts_on = 1'b0;
        rx_level = 1'b1;
        nbits = 4'h8;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_pointer;
        t_frames;
        t_rts(8'h00, 8'h20, 1'b1);
        t_rts(8'h00, 8'h00, 1'b0);
        t_rts(8'h80, 8'h20, 1'b0);
        t_rts(8'h80, 8'h00, 1'b0);
        t_chmode;
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test;
    end
endmodule : tb_uart_mode_config
`default_nettype wire

// *** sim/umc_asserts.sv ***
// assertion checker for the serial mode configuration block
`timescale 1ns/1ns
`default_nettype none
module umc_asserts #(
    parameter int BIT_CYCLES = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and configuration
    input wire logic rxd,
    input wire logic cts_n,
    input wire logic txd,
    input wire logic rts_n,
    input wire logic [1:0] channel_mode_field,
    input wire logic rx_rts_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // length of the current low run on the line
    int low_cnt_r;
    always_ff @(posedge clk) begin
        if (reset || txd) begin
            low_cnt_r <= 0;
        end else begin
            low_cnt_r <= low_cnt_r + 1;
        end
    end
    sequence loop_steady;
        (channel_mode_field[0] && $stable(rxd))[*8];
    endsequence
    sequence req_answered;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    // ==========================================
    chk_pins_reset: assert property ($fell(reset) |-> avs_waitrequest && txd && rts_n)
        else $error("outputs not idle after reset");
    chk_wait_one: assert property (req_answered |=> avs_waitrequest)
        else $error("wait request low for more than one cycle");
    chk_wait_cause: assert property (!avs_waitrequest |-> avs_read || avs_write)
        else $error("answer without a request");
    chk_read_hold: assert property ($changed(avs_readdata) |-> $past(avs_read) && !avs_waitrequest)
        else $error("read data changed outside a read");
    chk_local_idle: assert property (channel_mode_field == umc_pkg::CHMODE_LOCAL
        && $past(channel_mode_field, 2) == umc_pkg::CHMODE_LOCAL |-> txd)
        else $error("line not idle in local loop");
    chk_echo_follow: assert property (loop_steady |-> txd == rxd)
        else $error("line does not follow input in echo");
    chk_bit_multiple: assert property ($rose(txd) && channel_mode_field == umc_pkg::CHMODE_NORMAL
        |-> low_cnt_r > 0 && low_cnt_r % BIT_CYCLES == 0)
        else $error("low run not a whole number of bit times");
    chk_rts_cause: assert property ($fell(rts_n) |-> $past(avs_write, 2) || $past(avs_write, 3))
        else $error("request to send asserted without a command");
endmodule : umc_asserts

bind umc_top umc_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_asserts (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
    .channel_mode_field(channel_mode_field), .rx_rts_active(rx_rts_active));
`default_nettype wire

// *** sim/umc_remote.sv ***
// remote serial device: drives cts and rxd, captures frames from txd
`timescale 1ns/1ns
`default_nettype none
module umc_remote #(
    parameter int BIT_CYCLES = 8
) (
    // clock and line
    input wire logic clk,
    input wire logic txd,
    // control from the bench
    input wire logic cts_on,
    input wire logic rx_level,
    input wire logic [3:0] nbits,
    // pins toward the channel
    output logic cts_n,
    output logic rxd,
    // captured frame
    output logic [8:0] frame,
    output logic stop_bit,
    output logic [7:0] frames
);
    logic [8:0] sh;
    assign cts_n = !cts_on;
    assign rxd = rx_level;
    initial begin
        frame = 9'h000;
        stop_bit = 1'b0;
        frames = 8'h00;
        forever begin
            @(negedge txd);
            // sample every bit at its middle
            repeat (BIT_CYCLES / 2) @(posedge clk);
            if (txd === 1'b0) begin
                sh = 9'h000;
                for (int i = 0; i < nbits; i++) begin
                    repeat (BIT_CYCLES) @(posedge clk);
                    sh[i] = txd;
                end
                repeat (BIT_CYCLES) @(posedge clk);
                stop_bit = txd;
                frame = sh;
                frames = frames + 8'h01;
            end
        end
    end
endmodule : umc_remote
`default_nettype wire

// *** src/umc_par.sv ***
// parity bit generator for the configured character
`timescale 1ns/1ns
`default_nettype none
module umc_par (
    // character and configuration
    input wire logic [7:0] data,
    input wire logic [1:0] char_len,
    input wire logic [1:0] parity_mode_field,
    input wire logic parity_type_select,
    // result
    output logic par_bit,
    output logic par_en
);
    logic [7:0] mask;
    logic xsum;

    always_comb begin
        unique case (char_len)
            2'h0: mask = 8'h1F;
            2'h1: mask = 8'h3F;
            2'h2: mask = 8'h7F;
            2'h3: mask = 8'hFF;
        endcase
        xsum = ^(data & mask);
        par_en = 1'b1;
        unique case (parity_mode_field)
            umc_pkg::PAR_WITH: par_bit = xsum ^ parity_type_select;
            umc_pkg::PAR_FORCE: par_bit = parity_type_select;
            umc_pkg::PAR_NONE: begin
                par_bit = 1'b0;
                par_en = 1'b0;
            end
            umc_pkg::PAR_MULTI: par_bit = parity_type_select;
        endcase
    end
endmodule : umc_par
`default_nettype wire

// *** src/umc_pkg.sv ***
// constants for the serial channel mode configuration block
package umc_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CMD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_TXDATA = 4'hC;
    // ==========================================
    // command codes written to ADDR_CMD
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_PTR_RESET = 3'h1;
    localparam logic [2:0] CMD_TX_ENABLE = 3'h2;
    localparam logic [2:0] CMD_TX_DISABLE = 3'h3;
    localparam logic [2:0] CMD_RTS_SET = 3'h4;
    localparam logic [2:0] CMD_RTS_CLEAR = 3'h5;
    // ==========================================
    // first mode register fields
    localparam int RX_RTS_BIT = 7;
    localparam int PAR_MODE_HI = 4;
    localparam int PAR_MODE_LO = 3;
    localparam int PAR_TYPE_BIT = 2;
    localparam int CHAR_LEN_HI = 1;
    localparam int CHAR_LEN_LO = 0;
    // second mode register fields
    localparam int CHAN_MODE_HI = 7;
    localparam int CHAN_MODE_LO = 6;
    localparam int TX_RTS_BIT = 5;
    localparam int TX_CTS_BIT = 4;
    // status bits
    localparam int ST_PTR_BIT = 0;
    localparam int ST_TX_EN_BIT = 1;
    localparam int ST_TX_BUSY_BIT = 2;
    localparam int ST_TX_FULL_BIT = 3;
    localparam int ST_RTS_BIT = 4;
    localparam int ST_CTS_BIT = 5;
    // ==========================================
    // reset values
    localparam logic [7:0] MODE1_RST = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h00;
    // ==========================================
    // encodings
    localparam logic [1:0] PAR_WITH = 2'h0;
    localparam logic [1:0] PAR_FORCE = 2'h1;
    localparam logic [1:0] PAR_NONE = 2'h2;
    localparam logic [1:0] PAR_MULTI = 2'h3;
    localparam logic [1:0] CHMODE_NORMAL = 2'h0;
    localparam logic [1:0] CHMODE_ECHO = 2'h1;
    localparam logic [1:0] CHMODE_LOCAL = 2'h2;
    localparam logic [1:0] CHMODE_REMOTE = 2'h3;
    localparam logic [3:0] DATA_BITS_BASE = 4'h5;
    // ==========================================
    // timing
    localparam int CLK_HZ = 10000000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
    localparam int BUS_WAIT_CYCLES = 1;
endpackage : umc_pkg

// *** src/umc_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module umc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pin in, filtered level out
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            dout <= 1'b0;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule : umc_sync
`default_nettype wire

// *** src/umc_top.sv ***
// mode configuration and transmit path of one serial channel
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module umc_top #(
    parameter int BIT_CYCLES = umc_pkg::BIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    // serial pins
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd,
    output logic rts_n,
    // configuration seen by the channel
    output logic [1:0] channel_mode_field,
    output logic rx_rts_active
);
    // ==========================================
    // types and declarations
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } umc_tx_state_t;

    localparam int CW = $clog2(BIT_CYCLES + 1);

    logic [7:0] mode_config_first_r;
    logic [7:0] mode_config_second_r;
    logic ptr_second_r;
    logic access_r;
    logic tx_en_r;
    logic hold_full_r;
    logic [7:0] hold_r;
    logic [7:0] shift_r;
    logic [2:0] bit_idx_r;
    logic [CW-1:0] bit_cnt_r;
    logic [CW-1:0] rts_cnt_r;
    logic rts_wait_r;
    logic output_port_bits_r;
    logic cts_sync;
    logic rxd_sync;
    logic par_bit;
    logic par_en;
    logic line_tx;
    logic take_req;
    logic bit_end;
    logic char_done;
    logic tx_rts_auto_release;
    logic tx_cts_gating_enable;
    logic [1:0] char_len;
    logic [2:0] last_idx;
    umc_tx_state_t tx_state_r;
    umc_tx_state_t tx_state_nxt;

    // ==========================================
    // pin synchronisers
    umc_sync u_cts (
        .clk(clk),
        .reset(reset),
        .din(~cts_n),
        .dout(cts_sync)
    );

    umc_sync u_rxd (
        .clk(clk),
        .reset(reset),
        .din(rxd),
        .dout(rxd_sync)
    );

    // ==========================================
    // configuration decode
    assign char_len = mode_config_first_r[umc_pkg::CHAR_LEN_HI:umc_pkg::CHAR_LEN_LO];
    assign last_idx = 3'(umc_pkg::DATA_BITS_BASE + {2'h0, char_len} - 4'h1);
    // conflicting rts set-up cancels both
    assign tx_rts_auto_release = mode_config_second_r[umc_pkg::TX_RTS_BIT]
        & ~mode_config_first_r[umc_pkg::RX_RTS_BIT];
    assign tx_cts_gating_enable = mode_config_second_r[umc_pkg::TX_CTS_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            channel_mode_field <= umc_pkg::CHMODE_NORMAL;
            rx_rts_active <= 1'b0;
        end else begin
            channel_mode_field <= mode_config_second_r[umc_pkg::CHAN_MODE_HI:umc_pkg::CHAN_MODE_LO];
            rx_rts_active <= mode_config_first_r[umc_pkg::RX_RTS_BIT]
                & ~mode_config_second_r[umc_pkg::TX_RTS_BIT];
        end
    end

    // ==========================================
    // bus slave: one wait cycle, answer on second edge
    assign take_req = (avs_read | avs_write) & ~access_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            access_r <= 1'b0;
        end else begin
            access_r <= take_req;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~take_req;
        end
    end

    // ==========================================
    // mode registers and pointer
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_config_first_r <= umc_pkg::MODE1_RST;
            mode_config_second_r <= umc_pkg::MODE2_RST;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_MODE) begin
            if (ptr_second_r) begin
                mode_config_second_r <= avs_writedata;
            end else begin
                mode_config_first_r <= avs_writedata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_second_r <= 1'b0;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_CMD
                     && avs_writedata[2:0] == umc_pkg::CMD_PTR_RESET) begin
            ptr_second_r <= 1'b0;
        end else if (access_r && avs_address == umc_pkg::ADDR_MODE && !ptr_second_r) begin
            ptr_second_r <= 1'b1;
        end
    end

    // ==========================================
    // read data
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 8'h00;
        end else if (take_req && avs_read) begin
            unique case (avs_address)
                umc_pkg::ADDR_MODE: begin
                    avs_readdata <= ptr_second_r ? mode_config_second_r
                        : mode_config_first_r;
                end
                umc_pkg::ADDR_STATUS: begin
                    avs_readdata <= 8'h00;
                    avs_readdata[umc_pkg::ST_PTR_BIT] <= ptr_second_r;
                    avs_readdata[umc_pkg::ST_TX_EN_BIT] <= tx_en_r;
                    avs_readdata[umc_pkg::ST_TX_BUSY_BIT] <= tx_state_r != TX_IDLE;
                    avs_readdata[umc_pkg::ST_TX_FULL_BIT] <= hold_full_r;
                    avs_readdata[umc_pkg::ST_RTS_BIT] <= output_port_bits_r;
                    avs_readdata[umc_pkg::ST_CTS_BIT] <= cts_sync;
                end
                default: avs_readdata <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // commands and holding register
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_en_r <= 1'b0;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_CMD) begin
            if (avs_writedata[2:0] == umc_pkg::CMD_TX_ENABLE) begin
                tx_en_r <= 1'b1;
            end else if (avs_writedata[2:0] == umc_pkg::CMD_TX_DISABLE) begin
                tx_en_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_full_r <= 1'b0;
            hold_r <= 8'h00;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_TXDATA
                     && tx_en_r && !hold_full_r) begin
            hold_full_r <= 1'b1;
            hold_r <= avs_writedata;
        end else if (tx_state_r == TX_IDLE && tx_state_nxt == TX_START) begin
            hold_full_r <= 1'b0;
        end
    end

    // ==========================================
    // transmitter
    umc_par u_par (
        .data(shift_r),
        .char_len(char_len),
        .parity_mode_field(mode_config_first_r[umc_pkg::PAR_MODE_HI:umc_pkg::PAR_MODE_LO]),
        .parity_type_select(mode_config_first_r[umc_pkg::PAR_TYPE_BIT]),
        .par_bit(par_bit),
        .par_en(par_en)
    );

    assign bit_end = bit_cnt_r == CW'(BIT_CYCLES - 1);
    assign char_done = tx_state_r == TX_STOP && bit_end;

    always_comb begin
        tx_state_nxt = tx_state_r;
        unique case (tx_state_r)
            TX_IDLE: begin
                // cts checked before each character
                if (hold_full_r && (!tx_cts_gating_enable || cts_sync)) begin
                    tx_state_nxt = TX_START;
                end
            end
            TX_START: if (bit_end) tx_state_nxt = TX_DATA;
            TX_DATA: begin
                if (bit_end && bit_idx_r == last_idx) begin
                    tx_state_nxt = par_en ? TX_PAR : TX_STOP;
                end
            end
            TX_PAR: if (bit_end) tx_state_nxt = TX_STOP;
            TX_STOP: if (bit_end) tx_state_nxt = TX_IDLE;
            default: tx_state_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_r <= TX_IDLE;
            bit_cnt_r <= '0;
            bit_idx_r <= 3'h0;
            shift_r <= 8'h00;
        end else begin
            tx_state_r <= tx_state_nxt;
            if (tx_state_r == TX_IDLE || bit_end) begin
                bit_cnt_r <= '0;
            end else begin
                bit_cnt_r <= bit_cnt_r + CW'(1);
            end
            if (tx_state_r == TX_IDLE && tx_state_nxt == TX_START) begin
                shift_r <= hold_r;
                bit_idx_r <= 3'h0;
            end else if (tx_state_r == TX_DATA && bit_end) begin
                bit_idx_r <= bit_idx_r + 3'h1;
            end
        end
    end

    always_comb begin
        unique case (tx_state_r)
            TX_START: line_tx = 1'b0;
            TX_DATA: line_tx = shift_r[bit_idx_r];
            TX_PAR: line_tx = par_bit;
            default: line_tx = 1'b1;
        endcase
    end

    // ==========================================
    // looping modes on the transmit pin
    always_ff @(posedge clk) begin
        if (reset) begin
            txd <= 1'b1;
        end else begin
            unique case (channel_mode_field)
                umc_pkg::CHMODE_NORMAL: txd <= line_tx;
                umc_pkg::CHMODE_ECHO: txd <= rxd_sync;
                umc_pkg::CHMODE_LOCAL: txd <= 1'b1;
                umc_pkg::CHMODE_REMOTE: txd <= rxd_sync;
            endcase
        end
    end

    // ==========================================
    // rts output port bit and automatic release
    always_ff @(posedge clk) begin
        if (reset) begin
            rts_wait_r <= 1'b0;
            rts_cnt_r <= '0;
        end else if (!tx_rts_auto_release) begin
            rts_wait_r <= 1'b0;
            rts_cnt_r <= '0;
        end else if (rts_wait_r) begin
            rts_cnt_r <= rts_cnt_r + CW'(1);
            if (rts_cnt_r == CW'(BIT_CYCLES - 1)) begin
                rts_wait_r <= 1'b0;
            end
        end else if (!tx_en_r && !hold_full_r && tx_state_r == TX_IDLE
                     && output_port_bits_r) begin
            rts_wait_r <= 1'b1;
            rts_cnt_r <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            output_port_bits_r <= 1'b0;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_CMD
                     && avs_writedata[2:0] == umc_pkg::CMD_RTS_SET) begin
            output_port_bits_r <= 1'b1;
        end else if (access_r && avs_write && avs_address == umc_pkg::ADDR_CMD
                     && avs_writedata[2:0] == umc_pkg::CMD_RTS_CLEAR) begin
            output_port_bits_r <= 1'b0;
        end else if (rts_wait_r && tx_rts_auto_release && !tx_en_r
                     && rts_cnt_r == CW'(BIT_CYCLES - 1)) begin
            output_port_bits_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rts_n <= 1'b1;
        end else begin
            rts_n <= ~output_port_bits_r;
        end
    end
endmodule : umc_top
`default_nettype wire
